// [design/fpet_defines.vh]
// constants for the flash program/erase timing block
`ifndef FPET_DEFINES_VH
`define FPET_DEFINES_VH

// ------------------------------------------------------------
// register indices on the cpu register port
// ------------------------------------------------------------
`define FPET_OFS_STATUS 4'h0
`define FPET_OFS_PSR 4'h1
`define FPET_OFS_START 4'h2
`define FPET_OFS_TRAN 4'h3
`define FPET_OFS_PROG 4'h4
`define FPET_OFS_PERASE 4'h5
`define FPET_OFS_MERASE 4'h6
`define FPET_OFS_END 4'h7
`define FPET_OFS_MEND 4'h8
`define FPET_OFS_RCV 4'h9
`define FPET_OFS_FUNC 4'hA
`define FPET_OFS_FUNC_MIR 4'hB
`define FPET_OFS_PROT 4'hC
`define FPET_OFS_PROT_MIR 4'hD
`define FPET_OFS_CODE 4'hE
`define FPET_OFS_CODE_MIR 4'hF

// ------------------------------------------------------------
// status field positions
// ------------------------------------------------------------
`define FPET_ST_ERASE_FAULT 0
`define FPET_ST_PROG_FAULT 1
`define FPET_ST_BUSY 2
`define FPET_ST_FULL 3
`define FPET_ST_LOSS 4

// ------------------------------------------------------------
// reset values of the reload registers
// ------------------------------------------------------------
`define FPET_RST_PSR 5'h04
`define FPET_RST_START 8'h18
`define FPET_RST_TRAN 8'h30
`define FPET_RST_PROG 8'h16
`define FPET_RST_PERASE 8'h04
`define FPET_RST_MERASE 8'hEA
`define FPET_RST_END 8'h18
`define FPET_RST_MEND 8'h3C
`define FPET_RST_RCV 8'h04

// ------------------------------------------------------------
// timing multipliers as shift counts, field positions, op kinds
// ------------------------------------------------------------
`define FPET_SH_ONE 4'h0
`define FPET_SH_PROG 4'h3
`define FPET_SH_ERASE 4'hC
`define FPET_SH_MEND 4'h3
`define FPET_FW_XCVR_BIT 0
`define FPET_BOOT_HI 3
`define FPET_BOOT_LO 0
`define FPET_OP_PROG 2'h0
`define FPET_OP_PAGE 2'h1
`define FPET_OP_MODULE 2'h2

`endif

// [design/fpet_flash_timing.v]
// flash program/erase timing, status and auto-read registers
//
// Function
// - status register reads all zero after reset
// - erase failure sets erase fault; write 1 clears, 0 ignored
// - program failure sets program fault; write 1 clears, 0 ignored
// - buffer overrun sets data loss flag; write 1 clears, 0 ignored
// - busy high during program or erase; new requests stall cpu
// - buffer full reads 1 when no request fits, else 0
// - with interrupt enable set, interrupt when buffer frees
// - timing tick is system clock divided by divisor plus one
// - start delay lasts start count plus one ticks
// - transition delay lasts transition count plus one ticks
// - program pulse lasts eight times program count plus one ticks
// - page erase pulse lasts 4096 times count plus one ticks
// - module erase pulse lasts 4096 times count plus one ticks
// - end delay lasts end count plus one ticks
// - module erase end lasts eight times count plus one ticks
// - recovery delay lasts recovery count plus one ticks
// - function word sampled at reset, readable twice via mirror
// - transceiver forced low power unless function word allows it
// - protection word sampled at reset, readable twice via mirror
// - code start: low nine and top three bits zero, middle inverted boot
// - code start value drives the boot branch displacement
// - interrupt enable low means no interrupt when buffer frees
`timescale 1ns/1ps
`default_nettype none
`include "fpet_defines.vh"

module fpet_flash_timing (
   input wire clk_sys,
   input wire srst,
   input wire reg_wr_en,
   input wire reg_rd_en,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   output reg [15:0] reg_rdata_reg,
   input wire op_req,
   input wire [1:0] op_kind,
   input wire array_fail,
   input wire program_interrupt_enable,
   input wire [15:0] info_function_word,
   input wire [15:0] info_protection_word,
   input wire usb_ctrl_lowpower,
   output reg array_busy_flag_reg,
   output reg cpu_stall_reg,
   output reg prog_irq_reg,
   output reg array_prog_pulse_reg,
   output reg array_erase_pulse_reg,
   output reg array_module_sel_reg,
   output reg xcvr_lowpower_reg,
   output reg [15:0] boot_displacement_reg
);

   // ------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_START = 3'h1;
   localparam [2:0] S_TRAN = 3'h2;
   localparam [2:0] S_PULSE = 3'h3;
   localparam [2:0] S_END = 3'h4;
   localparam [2:0] S_RCV = 3'h5;

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   reg [4:0] prescale_divisor_reg;
   reg [7:0] start_delay_count_reg;
   reg [7:0] transition_count_reg;
   reg [7:0] program_pulse_count_reg;
   reg [7:0] page_erase_count_reg;
   reg [7:0] module_erase_count_reg;
   reg [7:0] end_delay_count_reg;
   reg [7:0] module_end_count_reg;
   reg [7:0] recovery_count_reg;
   reg [15:0] function_word_copy_reg;
   reg [15:0] protection_word_copy_reg;
   reg [15:0] code_area_start_reg;
   reg erase_fault_flag_reg;
   reg program_fault_flag_reg;
   reg overrun_loss_flag_reg;
   reg write_buffer_full_flag_reg;
   reg [1:0] buf_kind_reg;
   reg [1:0] op_kind_reg;
   reg [4:0] pre_cnt_reg;
   reg tick_reg;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [20:0] seq_cnt_reg;
   reg [20:0] seq_cnt_next;
   reg [15:0] rdata_next;
   wire [7:0] status_word;
   wire st_wr;
   wire seq_done;
   wire pulse_end;
   wire buf_pop;
   wire buf_push;
   wire is_module;

   // ticks minus one for a count field scaled by a power of two
   function [20:0] fpet_load;
      input [7:0] n;
      input [3:0] sh;
      begin
         fpet_load = (({13'h0000, n} + 21'h000001) << sh) - 21'h000001;
      end
   endfunction

   assign st_wr = reg_wr_en && (reg_addr == `FPET_OFS_STATUS);
   assign seq_done = tick_reg && (seq_cnt_reg == 21'h000000);
   assign pulse_end = seq_done && (state_reg == S_PULSE);
   assign buf_pop = (state_reg == S_IDLE) && write_buffer_full_flag_reg;
   assign buf_push = op_req && !write_buffer_full_flag_reg;
   assign is_module = (op_kind_reg == `FPET_OP_MODULE);

   assign status_word = {3'h0,
                         overrun_loss_flag_reg,
                         write_buffer_full_flag_reg,
                         array_busy_flag_reg,
                         program_fault_flag_reg,
                         erase_fault_flag_reg};

   // ------------------------------------------------------------
   // timing reload registers
   // ------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (srst) begin
         prescale_divisor_reg <= `FPET_RST_PSR;
         start_delay_count_reg <= `FPET_RST_START;
         transition_count_reg <= `FPET_RST_TRAN;
         program_pulse_count_reg <= `FPET_RST_PROG;
         page_erase_count_reg <= `FPET_RST_PERASE;
         module_erase_count_reg <= `FPET_RST_MERASE;
         end_delay_count_reg <= `FPET_RST_END;
         module_end_count_reg <= `FPET_RST_MEND;
         recovery_count_reg <= `FPET_RST_RCV;
      end else if (reg_wr_en) begin
         case (reg_addr)
            `FPET_OFS_PSR: prescale_divisor_reg <= reg_wdata[4:0];
            `FPET_OFS_START: start_delay_count_reg <= reg_wdata[7:0];
            `FPET_OFS_TRAN: transition_count_reg <= reg_wdata[7:0];
            `FPET_OFS_PROG: program_pulse_count_reg <= reg_wdata[7:0];
            `FPET_OFS_PERASE: page_erase_count_reg <= reg_wdata[7:0];
            `FPET_OFS_MERASE: module_erase_count_reg <= reg_wdata[7:0];
            `FPET_OFS_END: end_delay_count_reg <= reg_wdata[7:0];
            `FPET_OFS_MEND: module_end_count_reg <= reg_wdata[7:0];
            `FPET_OFS_RCV: recovery_count_reg <= reg_wdata[7:0];
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // words sampled while reset is held
   // ------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (srst) begin
         function_word_copy_reg <= info_function_word;
         protection_word_copy_reg <= info_protection_word;
         code_area_start_reg <= {3'h0,
            ~info_protection_word[`FPET_BOOT_HI:`FPET_BOOT_LO],
            9'h000};
      end
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         xcvr_lowpower_reg <= 1'b1;
         boot_displacement_reg <= 16'h0000;
      end else begin
         xcvr_lowpower_reg <= ~function_word_copy_reg[`FPET_FW_XCVR_BIT]
                              | usb_ctrl_lowpower;
         boot_displacement_reg <= code_area_start_reg;
      end
   end

   // ------------------------------------------------------------
   // prescaler
   // ------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (srst) begin
         pre_cnt_reg <= 5'h00;
         tick_reg <= 1'b0;
      end else if (pre_cnt_reg >= prescale_divisor_reg) begin
         pre_cnt_reg <= 5'h00;
         tick_reg <= 1'b1;
      end else begin
         pre_cnt_reg <= pre_cnt_reg + 5'h01;
         tick_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // request buffer and status flags
   // ------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (srst) begin
         write_buffer_full_flag_reg <= 1'b0;
         buf_kind_reg <= `FPET_OP_PROG;
         erase_fault_flag_reg <= 1'b0;
         program_fault_flag_reg <= 1'b0;
         overrun_loss_flag_reg <= 1'b0;
         prog_irq_reg <= 1'b0;
      end else begin
         if (buf_push) begin
            write_buffer_full_flag_reg <= 1'b1;
            buf_kind_reg <= op_kind;
         end else if (buf_pop) begin
            write_buffer_full_flag_reg <= 1'b0;
         end
         // set wins over a clear written in the same cycle
         if (pulse_end && array_fail && !is_module
             && (op_kind_reg != `FPET_OP_PROG)) begin
            erase_fault_flag_reg <= 1'b1;
         end else if (pulse_end && array_fail && is_module) begin
            erase_fault_flag_reg <= 1'b1;
         end else if (st_wr && reg_wdata[`FPET_ST_ERASE_FAULT]) begin
            erase_fault_flag_reg <= 1'b0;
         end
         if (pulse_end && array_fail
             && (op_kind_reg == `FPET_OP_PROG)) begin
            program_fault_flag_reg <= 1'b1;
         end else if (st_wr && reg_wdata[`FPET_ST_PROG_FAULT]) begin
            program_fault_flag_reg <= 1'b0;
         end
         if (op_req && write_buffer_full_flag_reg) begin
            overrun_loss_flag_reg <= 1'b1;
         end else if (st_wr && reg_wdata[`FPET_ST_LOSS]) begin
            overrun_loss_flag_reg <= 1'b0;
         end
         prog_irq_reg <= buf_pop && program_interrupt_enable;
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always @* begin
      state_next = state_reg;
      seq_cnt_next = seq_cnt_reg;
      if (tick_reg && (seq_cnt_reg != 21'h000000)) begin
         seq_cnt_next = seq_cnt_reg - 21'h000001;
      end
      case (state_reg)
         S_IDLE: begin
            if (buf_pop) begin
               state_next = S_START;
               seq_cnt_next = fpet_load(start_delay_count_reg,
                                        `FPET_SH_ONE);
            end
         end
         S_START: begin
            if (seq_done) begin
               state_next = S_TRAN;
               seq_cnt_next = fpet_load(transition_count_reg,
                                        `FPET_SH_ONE);
            end
         end
         S_TRAN: begin
            if (seq_done) begin
               state_next = S_PULSE;
               if (op_kind_reg == `FPET_OP_PROG) begin
                  seq_cnt_next = fpet_load(program_pulse_count_reg,
                                           `FPET_SH_PROG);
               end else if (is_module) begin
                  seq_cnt_next = fpet_load(module_erase_count_reg,
                                           `FPET_SH_ERASE);
               end else begin
                  seq_cnt_next = fpet_load(page_erase_count_reg,
                                           `FPET_SH_ERASE);
               end
            end
         end
         S_PULSE: begin
            if (seq_done) begin
               state_next = S_END;
               if (is_module) begin
                  seq_cnt_next = fpet_load(module_end_count_reg,
                                           `FPET_SH_MEND);
               end else begin
                  seq_cnt_next = fpet_load(end_delay_count_reg,
                                           `FPET_SH_ONE);
               end
            end
         end
         S_END: begin
            if (seq_done) begin
               state_next = S_RCV;
               seq_cnt_next = fpet_load(recovery_count_reg,
                                        `FPET_SH_ONE);
            end
         end
         S_RCV: begin
            if (seq_done) begin
               state_next = S_IDLE;
            end
         end
         default: begin
            state_next = S_IDLE;
            seq_cnt_next = 21'h000000;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         state_reg <= S_IDLE;
         seq_cnt_reg <= 21'h000000;
         op_kind_reg <= `FPET_OP_PROG;
         array_busy_flag_reg <= 1'b0;
         cpu_stall_reg <= 1'b0;
         array_prog_pulse_reg <= 1'b0;
         array_erase_pulse_reg <= 1'b0;
         array_module_sel_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         seq_cnt_reg <= seq_cnt_next;
         if (buf_pop) begin
            op_kind_reg <= buf_kind_reg;
         end
         array_busy_flag_reg <= (state_next != S_IDLE);
         if (state_next == S_IDLE) begin
            cpu_stall_reg <= 1'b0;
         end else if (op_req && array_busy_flag_reg) begin
            cpu_stall_reg <= 1'b1;
         end
         array_prog_pulse_reg <= (state_next == S_PULSE)
                                 && (op_kind_reg == `FPET_OP_PROG);
         array_erase_pulse_reg <= (state_next == S_PULSE)
                                  && (op_kind_reg != `FPET_OP_PROG);
         // a popped request's kind reaches op_kind_reg only at this edge
         array_module_sel_reg <= (state_next != S_IDLE) && (buf_pop
            ? (buf_kind_reg == `FPET_OP_MODULE) : is_module);
      end
   end

   // ------------------------------------------------------------
   // register read port
   // ------------------------------------------------------------
   always @* begin
      case (reg_addr)
         `FPET_OFS_STATUS: rdata_next = {8'h00, status_word};
         `FPET_OFS_PSR: rdata_next = {11'h000, prescale_divisor_reg};
         `FPET_OFS_START: rdata_next = {8'h00, start_delay_count_reg};
         `FPET_OFS_TRAN: rdata_next = {8'h00, transition_count_reg};
         `FPET_OFS_PROG: rdata_next = {8'h00, program_pulse_count_reg};
         `FPET_OFS_PERASE: rdata_next = {8'h00, page_erase_count_reg};
         `FPET_OFS_MERASE: rdata_next = {8'h00, module_erase_count_reg};
         `FPET_OFS_END: rdata_next = {8'h00, end_delay_count_reg};
         `FPET_OFS_MEND: rdata_next = {8'h00, module_end_count_reg};
         `FPET_OFS_RCV: rdata_next = {8'h00, recovery_count_reg};
         `FPET_OFS_FUNC: rdata_next = function_word_copy_reg;
         `FPET_OFS_FUNC_MIR: rdata_next = function_word_copy_reg;
         `FPET_OFS_PROT: rdata_next = protection_word_copy_reg;
         `FPET_OFS_PROT_MIR: rdata_next = protection_word_copy_reg;
         `FPET_OFS_CODE: rdata_next = code_area_start_reg;
         `FPET_OFS_CODE_MIR: rdata_next = code_area_start_reg;
         default: rdata_next = 16'h0000;
      endcase
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         reg_rdata_reg <= 16'h0000;
      end else if (reg_rd_en) begin
         reg_rdata_reg <= rdata_next;
      end
   end

endmodule
`default_nettype wire

// [test/fpet_timing_checker.sv]
// assertion checker for the flash timing block
`timescale 1ns/1ps
`default_nettype none
module fpet_timing_checker (
   input wire clk_sys,
   input wire srst,
   input wire op_req,
   input wire program_interrupt_enable,
   input wire [15:0] info_function_word,
   input wire [15:0] info_protection_word,
   input wire usb_ctrl_lowpower,
   input wire [15:0] reg_rdata_reg,
   input wire array_busy_flag_reg,
   input wire cpu_stall_reg,
   input wire prog_irq_reg,
   input wire array_prog_pulse_reg,
   input wire array_erase_pulse_reg,
   input wire xcvr_lowpower_reg,
   input wire [15:0] boot_displacement_reg
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   property p_rst;
      disable iff (1'b0) srst |=> reg_rdata_reg == 16'h0000 && !array_busy_flag_reg;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   property p_boot;
      disable iff (1'b0) srst ##1 !srst |=>
         boot_displacement_reg == {3'h0, ~$past(info_protection_word[3:0], 2), 9'h000};
   endproperty
   a_boot: assert property (p_boot) else $error("boot displacement wrong");
   property p_xcvr;
      disable iff (1'b0) srst ##1 !srst |=>
         xcvr_lowpower_reg == (!$past(info_function_word[0], 2) || $past(usb_ctrl_lowpower));
   endproperty
   a_xcvr: assert property (p_xcvr) else $error("transceiver power wrong");
   property p_stall;
      op_req && array_busy_flag_reg |=> cpu_stall_reg || !array_busy_flag_reg;
   endproperty
   a_stall: assert property (p_stall) else $error("no stall on busy request");
   property p_stall_end;
      $fell(array_busy_flag_reg) |-> ##[0:1] !cpu_stall_reg;
   endproperty
   a_stall_end: assert property (p_stall_end) else $error("stall outlives busy");
   property p_pulse_busy;
      array_prog_pulse_reg || array_erase_pulse_reg |-> array_busy_flag_reg;
   endproperty
   a_pulse_busy: assert property (p_pulse_busy) else $error("pulse while idle");
   property p_excl;
      !(array_prog_pulse_reg && array_erase_pulse_reg);
   endproperty
   a_excl: assert property (p_excl) else $error("both pulses at once");
   property p_irq_off;
      !program_interrupt_enable [*2] |-> !prog_irq_reg;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
   property p_irq;
      prog_irq_reg |-> array_busy_flag_reg ##1 !prog_irq_reg;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not a busy pulse");
   property p_start;
      op_req && !array_busy_flag_reg |-> ##[1:3] array_busy_flag_reg;
   endproperty
   a_start: assert property (p_start) else $error("request did not start");
endmodule
bind fpet_flash_timing fpet_timing_checker u_chk (.clk_sys(clk_sys), .srst(srst),
   .op_req(op_req), .program_interrupt_enable(program_interrupt_enable),
   .info_function_word(info_function_word), .info_protection_word(info_protection_word),
   .usb_ctrl_lowpower(usb_ctrl_lowpower), .reg_rdata_reg(reg_rdata_reg),
   .array_busy_flag_reg(array_busy_flag_reg), .cpu_stall_reg(cpu_stall_reg),
   .prog_irq_reg(prog_irq_reg), .array_prog_pulse_reg(array_prog_pulse_reg),
   .array_erase_pulse_reg(array_erase_pulse_reg), .xcvr_lowpower_reg(xcvr_lowpower_reg),
   .boot_displacement_reg(boot_displacement_reg));
`default_nettype wire

// [test/fpet_array_model.sv]
// flash array model: answers pulses, failing on command
`timescale 1ns/1ps
`default_nettype none
module fpet_array_model (
   input wire prog_pulse,
   input wire erase_pulse,
   input wire fail_cmd,
   output wire array_fail
);
   // failure shows only while a pulse is applied
   assign array_fail = fail_cmd && (prog_pulse || erase_pulse);
endmodule
`default_nettype wire

// [test/tb_fpet_flash_timing.sv]
// self-checking bench for the flash timing block
`timescale 1ns/1ps
`default_nettype none
`include "fpet_defines.vh"
module tb_fpet_flash_timing;
   localparam [79:0] RSTV = 80'h043C18EA041630180400;
   reg clk_sys, srst, reg_wr_en, reg_rd_en, op_req, ien, usb_lp, fail_cmd;
   reg [3:0] reg_addr;
   reg [15:0] reg_wdata, fw, pw, rd, rv, e;
   reg [1:0] op_kind;
   reg [7:0] cfg [1:9];
   wire [15:0] rdata, boot;
   wire busy, stall, irq, ppulse, epulse, msel, xcvr, afail;
   integer err_count, compares, seed, cyc, n_p, n_e, n_b, n_i, n_m, i, j, k, q, w, d, tk;
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   fpet_flash_timing u_dut (.clk_sys(clk_sys), .srst(srst), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_reg(rdata),
      .op_req(op_req), .op_kind(op_kind), .array_fail(afail), .program_interrupt_enable(ien),
      .info_function_word(fw), .info_protection_word(pw), .usb_ctrl_lowpower(usb_lp),
      .array_busy_flag_reg(busy), .cpu_stall_reg(stall), .prog_irq_reg(irq),
      .array_prog_pulse_reg(ppulse), .array_erase_pulse_reg(epulse), .array_module_sel_reg(msel),
      .xcvr_lowpower_reg(xcvr), .boot_displacement_reg(boot));
   fpet_array_model u_arr (.prog_pulse(ppulse), .erase_pulse(epulse), .fail_cmd(fail_cmd),
      .array_fail(afail));
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      n_p = n_p + ppulse;
      n_e = n_e + epulse;
      n_b = n_b + busy;
      n_i = n_i + irq;
      n_m = n_m + msel;
      if (cyc == 40000) begin
         err_count = err_count + 1;
         results;
      end
   end
   task results;
      begin
         $display("compares %0d mismatches %0d", compares, err_count);
         if (err_count == 0 && compares > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [3:0] a, input [15:0] v);
      begin
         @(posedge clk_sys);
         reg_wr_en <= 1'b1;
         reg_addr <= a;
         reg_wdata <= v;
         @(posedge clk_sys);
         reg_wr_en <= 1'b0;
      end
   endtask
   task rd_reg(input [3:0] a);
      begin
         @(posedge clk_sys);
         reg_rd_en <= 1'b1;
         reg_addr <= a;
         @(posedge clk_sys);
         reg_rd_en <= 1'b0;
         @(negedge clk_sys);
         rd = rdata;
      end
   endtask
   task op(input [1:0] kd, input f);
      begin
         @(posedge clk_sys);
         op_req <= 1'b1;
         op_kind <= kd;
         fail_cmd <= f;
         @(posedge clk_sys);
         op_req <= 1'b0;
      end
   endtask
   task wait_idle;
      begin
         q = 0;
         for (w = 0; w < 90000 && q < 4; w = w + 1) begin
            @(negedge clk_sys);
            q = busy === 1'b0 ? q + 1 : 0;
         end
      end
   endtask
   task do_reset(input [15:0] f, input [15:0] p);
      begin
         @(posedge clk_sys);
         srst <= 1'b1;
         fw <= f;
         pw <= p;
         repeat (12) @(posedge clk_sys);
         srst <= 1'b0;
         repeat (2) @(posedge clk_sys);
         @(negedge clk_sys);
      end
   endtask
   function integer pulse(input integer kk);
      pulse = kk == 0 ? 8 * (cfg[4] + 1) : 4096 * ((kk == 1 ? cfg[5] : cfg[6]) + 1);
   endfunction
   initial begin
      seed = 32'hC7E8635E;
      {err_count, compares, cyc, n_p, n_e, n_b, n_i, n_m} = 0;
      {srst, reg_wr_en, reg_rd_en, op_req, ien, usb_lp, fail_cmd} = 7'h40;
      {reg_addr, reg_wdata, op_kind, fw, pw} = 0;
      rv = $random(seed);
      do_reset({rv[15:1], 1'b0}, ~rv);
      chk(xcvr, 1'b1);
      chk(boot, {3'h0, ~pw[3:0], 9'h000});
      for (j = 0; j < 16; j = j + 1) begin
         if (j > 9)
            wr(j[3:0], 16'hFFFF);
         rd_reg(j[3:0]);
         e = j < 10 ? RSTV[j*8 +: 8] : j < 12 ? fw : j < 14 ? pw : {3'h0, ~pw[3:0], 9'h000};
         chk(rd, e);
      end
      do_reset(16'h0001, pw);
      chk(xcvr, 1'b0);
      @(posedge clk_sys);
      usb_lp <= 1'b1;
      repeat (3) @(negedge clk_sys);
      chk(xcvr, 1'b1);
      $display("test reset done");
      @(posedge clk_sys);
      ien <= 1'b1;
      for (i = 0; i < 6; i = i + 1) begin
         k = i % 3;
         for (j = 1; j < 10; j = j + 1) begin
            cfg[j] = $random(seed) & 7;
            if (k != 0 && (j == 1 || j == 5 || j == 6))
               cfg[j] = 0;
            wr(j[3:0], {8'h00, cfg[j]});
            rd_reg(j[3:0]);
            chk(rd, cfg[j]);
         end
         @(negedge clk_sys);
         {n_p, n_e, n_b, n_i, n_m} = 0;
         op(k[1:0], i > 2);
         wait_idle;
         d = cfg[1] + 1;
         chk(k == 0 ? n_p : n_e, pulse(k) * d);
         tk = cfg[2] + cfg[3] + cfg[9] + 3 + pulse(k) + (k == 2 ? 8 * (cfg[8] + 1) : cfg[7] + 1);
         tk = tk * d;
         chk(n_b >= tk - d && n_b <= tk + 2, 1);
         chk(n_i, 1);
         chk(n_m, k == 2 ? n_b : 0);
         e = i < 3 ? 0 : k == 0 ? 2 : 1;
         rd_reg(0);
         chk(rd, e);
         wr(0, 16'h0000);
         rd_reg(0);
         chk(rd, e);
         wr(0, 16'h0013);
         rd_reg(0);
         chk(rd, 0);
      end
      $display("test timing done");
      @(posedge clk_sys);
      ien <= 1'b0;
      n_i = 0;
      op(0, 1'b0);
      repeat (3) @(posedge clk_sys);
      op(0, 1'b0);
      @(negedge clk_sys);
      chk(stall, 1'b1);
      rd_reg(0);
      chk(rd, 16'h000C);
      op(0, 1'b0);
      rd_reg(0);
      chk(rd, 16'h001C);
      wait_idle;
      chk(n_i, 0);
      rd_reg(0);
      chk(rd, 16'h0010);
      wr(0, 16'h0010);
      rd_reg(0);
      chk(rd, 0);
      $display("test overrun done");
      results;
   end
endmodule
`default_nettype wire
